// File: bench/dss_plc_model.sv
// Controlling-party model that sends control words over the register port.
`include "dss_defs.svh"
`default_nettype none
module dss_plc_model (
  input wire logic clock,
  output logic [7:0] reg_addr,
  output dss_pkg::dss_word_t reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire dss_pkg::dss_word_t reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import dss_pkg::*;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // Commands sit in bits 0 to 3, qualifiers above them.
  task automatic write_cw(input dss_word_t w);
    @(posedge clock);
    reg_addr <= `DSS_ADDR_CTRL;
    reg_wdata <= w;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    // Released data is inverted so a stale copy never looks valid.
    reg_wdata <= ~w;
  endtask : write_cw
  task automatic read_reg(input logic [7:0] a, output dss_word_t d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : read_reg
  // The reset bit is shown low first so that the edge is real.
  task automatic fault_reset(input dss_word_t w);
    write_cw(w & 16'hff7f);
    write_cw(w | 16'h0080);
  endtask : fault_reset
endmodule : dss_plc_model
`default_nettype wire

// File: bench/test_drive_sequencing_state_machine.sv
// Self-checking bench for the drive sequencing state machine.
`include "dss_defs.svh"
`default_nettype none
module test_drive_sequencing_state_machine;
  timeunit 1ns;
  timeprecision 1ps;
  import dss_pkg::*;
  localparam int PSTOP = 0;
  localparam int PSHUT = 1;
  localparam int PQS = 2;
  localparam int PFR = 3;
  localparam int PTRIP = 4;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr;
  dss_word_t reg_wdata, reg_rdata, status_word, rd;
  logic reg_write, reg_read;
  logic [4:0] ev = 5'h00;
  logic init_done = 1'b0;
  logic faults_active = 1'b0;
  logic voltage_present = 1'b1;
  logic [2:0] seq_state;
  logic ramp_enable, stopping, shutting_down, fast_stopping, jogging, reverse;
  int n_fail = 0;
  int num_checks = 0;
  int cycles = 0;
  always #2 clock = ~clock;
  dss_sequencer uut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .init_done(init_done), .trip(ev[PTRIP]),
    .faults_active(faults_active), .stop_done(ev[PSTOP]),
    .shutdown_done(ev[PSHUT]), .quick_stop_done(ev[PQS]),
    .fault_reaction_done(ev[PFR]), .voltage_present(voltage_present),
    .seq_state(seq_state), .status_word(status_word),
    .ramp_enable(ramp_enable), .stopping(stopping),
    .shutting_down(shutting_down), .fast_stopping(fast_stopping),
    .jogging(jogging), .reverse(reverse));
  dss_plc_model plc (.clock(clock), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Bounded wait, so a missing transition shows as a mismatch, not a hang.
  task automatic wait_state(input logic [2:0] exp);
    for (int i = 0; i < 8 && seq_state !== exp; i++) @(posedge clock) #1;
    chk(16'(seq_state), 16'(exp));
  endtask : wait_state
  task automatic stay(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : stay
  task automatic pulse(input int k);
    @(posedge clock);
    ev[k] <= 1'b1;
    @(posedge clock);
    ev[k] <= 1'b0;
    #1;
  endtask : pulse
  task automatic to_op();
    plc.write_cw(16'h0006);
    wait_state(`DSS_CODE_READY);
    plc.write_cw(16'h0007);
    wait_state(`DSS_CODE_SWITCHED_ON);
    chk(16'(status_word[1]), 16'h0001);
    plc.write_cw(16'h000f);
    wait_state(`DSS_CODE_OP_ENABLED);
    chk(16'(ramp_enable), 16'h0001);
  endtask : to_op
  task automatic t_power();
    stay(3);
    chk(16'(seq_state), 16'(`DSS_CODE_NOT_READY));
    init_done <= 1'b1;
    wait_state(`DSS_CODE_SO_DISABLED);
    chk(16'(status_word[6]), 16'h0001);
  endtask : t_power
  task automatic t_walk();
    plc.write_cw(16'h0007);
    stay(4);
    chk(16'(seq_state), 16'(`DSS_CODE_SO_DISABLED));
    plc.write_cw(16'h4007);
    wait_state(`DSS_CODE_READY);
    plc.write_cw(16'h0002);
    wait_state(`DSS_CODE_SO_DISABLED);
    to_op();
    plc.write_cw(16'h100f);
    stay(3);
    chk(16'(jogging), 16'h0001);
    plc.write_cw(16'h0007);
    stay(4);
    chk(16'(seq_state), 16'(`DSS_CODE_OP_ENABLED));
    chk(16'(stopping), 16'h0001);
    pulse(PSTOP);
    chk(16'(seq_state), 16'(`DSS_CODE_SWITCHED_ON));
    plc.write_cw(16'h0006);
    wait_state(`DSS_CODE_READY);
    plc.write_cw(16'h0007);
    wait_state(`DSS_CODE_SWITCHED_ON);
    plc.write_cw(16'h0002);
    wait_state(`DSS_CODE_SO_DISABLED);
  endtask : t_walk
  task automatic t_stops();
    to_op();
    plc.write_cw(16'h0006);
    stay(4);
    chk(16'(shutting_down), 16'h0001);
    pulse(PSHUT);
    chk(16'(seq_state), 16'(`DSS_CODE_READY));
    plc.write_cw(16'h0000);
    wait_state(`DSS_CODE_SO_DISABLED);
    to_op();
    plc.write_cw(16'h000b);
    wait_state(`DSS_CODE_QUICK_STOP);
    chk(16'(fast_stopping), 16'h0001);
    pulse(PQS);
    chk(16'(seq_state), 16'(`DSS_CODE_SO_DISABLED));
    to_op();
    plc.write_cw(16'h0000);
    wait_state(`DSS_CODE_SO_DISABLED);
    to_op();
    plc.write_cw(16'h000b);
    wait_state(`DSS_CODE_QUICK_STOP);
    plc.write_cw(16'h0000);
    wait_state(`DSS_CODE_SO_DISABLED);
  endtask : t_stops
  task automatic t_fault();
    plc.write_cw(16'h0006);
    wait_state(`DSS_CODE_READY);
    // The trip lands in the cycle that decodes the switch-on command.
    plc.write_cw(16'h0007);
    ev[PTRIP] <= 1'b1;
    @(posedge clock);
    ev[PTRIP] <= 1'b0;
    #1;
    chk(16'(seq_state), 16'(`DSS_CODE_FAULT_REACT));
    pulse(PFR);
    chk(16'(seq_state), 16'(`DSS_CODE_FAULTED));
    chk(16'(status_word[3]), 16'h0001);
    faults_active <= 1'b1;
    plc.fault_reset(16'h0000);
    stay(4);
    chk(16'(seq_state), 16'(`DSS_CODE_FAULTED));
    faults_active <= 1'b0;
    stay(4);
    chk(16'(seq_state), 16'(`DSS_CODE_FAULTED));
    plc.fault_reset(16'h0000);
    wait_state(`DSS_CODE_SO_DISABLED);
    pulse(PTRIP);
    chk(16'(seq_state), 16'(`DSS_CODE_FAULT_REACT));
    plc.write_cw(16'h0000);
    wait_state(`DSS_CODE_FAULTED);
    plc.fault_reset(16'h0000);
    wait_state(`DSS_CODE_SO_DISABLED);
  endtask : t_fault
  // Exercises reverse, line supply status and the external fault bit.
  task automatic t_extra();
    to_op();
    plc.write_cw(16'h200f);
    stay(2);
    chk(16'(reverse), 16'h0001);
    chk(16'(status_word[13]), 16'h0001);
    voltage_present <= 1'b0;
    stay(2);
    chk(16'(status_word[4]), 16'h0000);
    voltage_present <= 1'b1;
    plc.write_cw(16'h0107);
    wait_state(`DSS_CODE_FAULT_REACT);
    pulse(PFR);
    chk(16'(seq_state), 16'(`DSS_CODE_FAULTED));
    plc.fault_reset(16'h0000);
    wait_state(`DSS_CODE_SO_DISABLED);
    chk(16'(status_word[4]), 16'h0001);
    chk(16'(reverse), 16'h0000);
  endtask : t_extra
  task automatic t_regs();
    plc.read_reg(`DSS_ADDR_STATE, rd);
    chk(rd, 16'(`DSS_CODE_SO_DISABLED));
    plc.read_reg(`DSS_ADDR_STATUS, rd);
    chk(16'(rd[6]), 16'h0001);
    plc.read_reg(8'h0c, rd);
    chk(rd, 16'h0000);
  endtask : t_regs
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  // The full sequence needs well under a thousand cycles.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    repeat (20) @(posedge clock);
    chk(16'(seq_state), 16'(`DSS_CODE_NOT_READY));
    sys_rst <= 1'b0;
    t_power();
    t_walk();
    t_stops();
    t_fault();
    t_regs();
    t_extra();
    summarize();
  end
endmodule : test_drive_sequencing_state_machine
`default_nettype wire

// File: rtl/dss_defs.svh
// Constants of the drive sequencing state machine.
// Behaviour
// (R1) Sequencing state reads as code 0 to 7, not ready up to faulted.
// (R2) Reset, standing for power-up, puts the machine in not ready.
// (R3) Not ready moves to switch-on disabled once initialisation is done.
// (R4) Switch-on disabled moves to ready to switch on on a shutdown command.
// (R5) Ready to switch on moves to switched on on a switch-on command.
// (R6) Switched on moves to operation enabled on an enable-operation command.
// (R7) Operation enabled returns to switched on after stop command and stop done.
// (R8) Switched on returns to ready to switch on on a shutdown command.
// (R9) Ready to switch on goes to switch-on disabled on quick stop or no voltage.
// (R10) Operation enabled goes to ready on shutdown once shutdown has finished.
// (R11) Operation enabled goes straight to switch-on disabled on disable voltage.
// (R12) Switched on goes to switch-on disabled on disable voltage or quick stop.
// (R13) Operation enabled goes to quick stop active on a quick-stop command.
// (R14) Quick stop active ends when the fast stop finishes or voltage is removed.
// (R15) A trip in any state enters fault reaction active.
// (R16) Fault reaction ends in faulted when finished or on disable voltage.
// (R17) Faulted goes to switch-on disabled on fault reset with no faults left.
// (R18) Operation enabled keeps the ramp on; running covers jogging too.
// (R19) Control word bits 0 to 3: switch on, coast stop low, fast stop low, run.
// (R20) Fault reset is taken only on a rising edge of control word bit 7.
// (R21) Control word bit 14 allows switch-on disabled to ready regardless of bit 0.
// (R22) Status bit 1 in switched on or operation enabled, bit 6 in disabled.
// (R23) Quick stop active leaves to switch-on disabled unless a trip takes it to fault reaction.
// (R24) A trip wins over any command transition in the same cycle; in fault reaction active the code still takes disable voltage to faulted.
`ifndef DSS_DEFS_SVH
`define DSS_DEFS_SVH

`define DSS_ADDR_CTRL 8'h00
`define DSS_ADDR_STATUS 8'h04
`define DSS_ADDR_STATE 8'h08

`define DSS_CTRL_RESET 16'h0000

`define DSS_CW_SWITCH_ON 0
`define DSS_CW_ENABLE_VOLTAGE 1
`define DSS_CW_NOT_QUICKSTOP 2
`define DSS_CW_ENABLE_OP 3
`define DSS_CW_FAULT_RESET 7
`define DSS_CW_EXT_FAULT 8
`define DSS_CW_JOG 12
`define DSS_CW_REVERSE 13
`define DSS_CW_AUTO_INIT 14
`define DSS_CW_EVENT_OP 15

`define DSS_SW_READY 0
`define DSS_SW_SWITCHED_ON 1
`define DSS_SW_OP_ENABLED 2
`define DSS_SW_FAULTED 3
`define DSS_SW_VOLTAGE 4
`define DSS_SW_QS_INACTIVE 5
`define DSS_SW_SO_DISABLED 6
`define DSS_SW_JOG 12
`define DSS_SW_REVERSE 13

`define DSS_CODE_NOT_READY 3'h0
`define DSS_CODE_SO_DISABLED 3'h1
`define DSS_CODE_READY 3'h2
`define DSS_CODE_SWITCHED_ON 3'h3
`define DSS_CODE_OP_ENABLED 3'h4
`define DSS_CODE_QUICK_STOP 3'h5
`define DSS_CODE_FAULT_REACT 3'h6
`define DSS_CODE_FAULTED 3'h7

`endif

// File: rtl/dss_pkg.sv
// Types shared by the drive sequencing state machine.
`default_nettype none
package dss_pkg;

  typedef enum logic [7:0] {
    DSS_NOT_READY = 8'b0000_0001,
    DSS_SO_DISABLED = 8'b0000_0010,
    DSS_READY = 8'b0000_0100,
    DSS_SWITCHED_ON = 8'b0000_1000,
    DSS_OP_ENABLED = 8'b0001_0000,
    DSS_QUICK_STOP = 8'b0010_0000,
    DSS_FAULT_REACT = 8'b0100_0000,
    DSS_FAULTED = 8'b1000_0000
  } dss_state_e;

  typedef enum logic [2:0] {
    DSS_SUB_IDLE = 3'b001,
    DSS_SUB_STOPPING = 3'b010,
    DSS_SUB_SHUTTING = 3'b100
  } dss_sub_e;

  typedef logic [15:0] dss_word_t;

endpackage : dss_pkg
`default_nettype wire

// File: rtl/dss_sequencer.sv
// Drive sequencing state machine with its control and status registers.
`include "dss_defs.svh"
`default_nettype none
module dss_sequencer #(
  parameter int ADDR_W = 8
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire dss_pkg::dss_word_t reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output dss_pkg::dss_word_t reg_rdata,
  input wire logic init_done,
  input wire logic trip,
  input wire logic faults_active,
  input wire logic stop_done,
  input wire logic shutdown_done,
  input wire logic quick_stop_done,
  input wire logic fault_reaction_done,
  input wire logic voltage_present,
  output logic [2:0] seq_state,
  output dss_pkg::dss_word_t status_word,
  output logic ramp_enable,
  output logic stopping,
  output logic shutting_down,
  output logic fast_stopping,
  output logic jogging,
  output logic reverse
);
  import dss_pkg::*;

  dss_state_e state;
  dss_state_e next_state;
  dss_sub_e sub;
  dss_word_t ctrl;
  logic fault_reset_prev;
  logic ext_fault_prev;
  logic enable_op_prev;

  function automatic logic [2:0] state_code(input dss_state_e s);
    case (s)
      DSS_NOT_READY: state_code = `DSS_CODE_NOT_READY;
      DSS_SO_DISABLED: state_code = `DSS_CODE_SO_DISABLED;
      DSS_READY: state_code = `DSS_CODE_READY;
      DSS_SWITCHED_ON: state_code = `DSS_CODE_SWITCHED_ON;
      DSS_OP_ENABLED: state_code = `DSS_CODE_OP_ENABLED;
      DSS_QUICK_STOP: state_code = `DSS_CODE_QUICK_STOP;
      DSS_FAULT_REACT: state_code = `DSS_CODE_FAULT_REACT;
      DSS_FAULTED: state_code = `DSS_CODE_FAULTED;
      default: state_code = `DSS_CODE_NOT_READY;
    endcase
  endfunction : state_code

  // Command decode of the control word bits.
  logic cmd_disable_voltage;
  logic cmd_quick_stop;
  logic cmd_shutdown;
  logic cmd_switch_on;
  logic cmd_enable_op;
  logic cmd_auto_init;
  logic fault_reset_edge;
  logic trip_event;

  always_comb begin
    cmd_disable_voltage = !ctrl[`DSS_CW_ENABLE_VOLTAGE]; // [R19]
    cmd_quick_stop = ctrl[`DSS_CW_ENABLE_VOLTAGE] &&
                     !ctrl[`DSS_CW_NOT_QUICKSTOP]; // [R19]
    cmd_shutdown = ctrl[`DSS_CW_ENABLE_VOLTAGE] &&
                   ctrl[`DSS_CW_NOT_QUICKSTOP] &&
                   !ctrl[`DSS_CW_SWITCH_ON]; // [R19]
    cmd_switch_on = ctrl[`DSS_CW_ENABLE_VOLTAGE] &&
                    ctrl[`DSS_CW_NOT_QUICKSTOP] &&
                    ctrl[`DSS_CW_SWITCH_ON]; // [R19]
    cmd_auto_init = ctrl[`DSS_CW_AUTO_INIT] &&
                    ctrl[`DSS_CW_ENABLE_VOLTAGE] &&
                    ctrl[`DSS_CW_NOT_QUICKSTOP]; // [R21]
    // With event-triggered run set, a held run bit must first be dropped,
    // so a drive returning to switched on cannot restart by itself.
    cmd_enable_op = cmd_switch_on && ctrl[`DSS_CW_ENABLE_OP] &&
                    (!ctrl[`DSS_CW_EVENT_OP] || !enable_op_prev);
    fault_reset_edge = ctrl[`DSS_CW_FAULT_RESET] &&
                       !fault_reset_prev; // [R20]
    trip_event = trip || (ctrl[`DSS_CW_EXT_FAULT] && !ext_fault_prev);
  end

  // Edge memories for the control bits that act on transitions.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fault_reset_prev <= 1'b0;
      ext_fault_prev <= 1'b0;
      enable_op_prev <= 1'b0;
    end else begin
      fault_reset_prev <= ctrl[`DSS_CW_FAULT_RESET]; // [R20]
      ext_fault_prev <= ctrl[`DSS_CW_EXT_FAULT];
      enable_op_prev <= ctrl[`DSS_CW_ENABLE_OP];
    end
  end

  always_comb begin
    next_state = state;
    if (trip_event && state != DSS_FAULT_REACT) begin
      next_state = DSS_FAULT_REACT; // [R15] [R24]
    end else begin
      case (state)
        DSS_NOT_READY: begin
          if (init_done) next_state = DSS_SO_DISABLED; // [R3]
        end
        DSS_SO_DISABLED: begin
          if (cmd_shutdown || cmd_auto_init) begin
            next_state = DSS_READY; // [R4] [R21]
          end
        end
        DSS_READY: begin
          if (cmd_disable_voltage || cmd_quick_stop) begin
            next_state = DSS_SO_DISABLED; // [R9]
          end else if (cmd_switch_on) begin
            next_state = DSS_SWITCHED_ON; // [R5]
          end
        end
        DSS_SWITCHED_ON: begin
          if (cmd_disable_voltage || cmd_quick_stop) begin
            next_state = DSS_SO_DISABLED; // [R12]
          end else if (cmd_shutdown) begin
            next_state = DSS_READY; // [R8]
          end else if (cmd_enable_op) begin
            next_state = DSS_OP_ENABLED; // [R6]
          end
        end
        DSS_OP_ENABLED: begin
          if (cmd_disable_voltage) begin
            next_state = DSS_SO_DISABLED; // [R11]
          end else if (cmd_quick_stop) begin
            next_state = DSS_QUICK_STOP; // [R13]
          end else if (sub == DSS_SUB_SHUTTING && cmd_shutdown &&
                       shutdown_done) begin
            next_state = DSS_READY; // [R10]
          end else if (sub == DSS_SUB_STOPPING && cmd_switch_on &&
                       !ctrl[`DSS_CW_ENABLE_OP] && stop_done) begin
            next_state = DSS_SWITCHED_ON; // [R7]
          end
        end
        DSS_QUICK_STOP: begin
          if (quick_stop_done || cmd_disable_voltage) begin
            next_state = DSS_SO_DISABLED; // [R14] [R23]
          end
        end
        DSS_FAULT_REACT: begin
          if (fault_reaction_done || cmd_disable_voltage) begin
            next_state = DSS_FAULTED; // [R16]
          end
        end
        DSS_FAULTED: begin
          if (fault_reset_edge && !faults_active) begin
            next_state = DSS_SO_DISABLED; // [R17]
          end
        end
        default: next_state = DSS_NOT_READY;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= DSS_NOT_READY; // [R2]
    end else begin
      state <= next_state;
    end
  end

  // Sub-state of operation enabled: the stop in progress is remembered so
  // that a command change mid-ramp restarts running instead of stalling.
  always_ff @(posedge clock) begin
    if (sys_rst || next_state != DSS_OP_ENABLED) begin
      sub <= DSS_SUB_IDLE;
    end else if (cmd_shutdown) begin
      sub <= DSS_SUB_SHUTTING;
    end else if (cmd_switch_on && !ctrl[`DSS_CW_ENABLE_OP]) begin
      sub <= DSS_SUB_STOPPING;
    end else begin
      sub <= DSS_SUB_IDLE; // [R18]
    end
  end

  // Control word register, written by the master.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl <= `DSS_CTRL_RESET;
    end else if (reg_write && reg_addr == ADDR_W'(`DSS_ADDR_CTRL)) begin
      ctrl <= reg_wdata;
    end
  end

  // Status word, rebuilt each cycle from the next state, the voltage input and control bits 12 and 13.
  dss_word_t next_status;
  always_comb begin
    next_status = 16'h0000;
    next_status[`DSS_SW_READY] = next_state inside
      {DSS_READY, DSS_SWITCHED_ON, DSS_OP_ENABLED};
    next_status[`DSS_SW_SWITCHED_ON] = next_state inside
      {DSS_SWITCHED_ON, DSS_OP_ENABLED}; // [R22]
    next_status[`DSS_SW_OP_ENABLED] = next_state == DSS_OP_ENABLED;
    next_status[`DSS_SW_FAULTED] = next_state inside
      {DSS_FAULT_REACT, DSS_FAULTED};
    next_status[`DSS_SW_VOLTAGE] = voltage_present;
    next_status[`DSS_SW_QS_INACTIVE] = next_state != DSS_QUICK_STOP;
    next_status[`DSS_SW_SO_DISABLED] =
      next_state == DSS_SO_DISABLED; // [R22]
    next_status[`DSS_SW_JOG] = ctrl[`DSS_CW_JOG];
    next_status[`DSS_SW_REVERSE] = ctrl[`DSS_CW_REVERSE];
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status_word <= 16'h0000;
      seq_state <= `DSS_CODE_NOT_READY;
      ramp_enable <= 1'b0;
      stopping <= 1'b0;
      shutting_down <= 1'b0;
      fast_stopping <= 1'b0;
      jogging <= 1'b0;
      reverse <= 1'b0;
    end else begin
      status_word <= next_status;
      seq_state <= state_code(next_state); // [R1]
      ramp_enable <= next_state == DSS_OP_ENABLED; // [R18]
      stopping <= next_state == DSS_OP_ENABLED &&
                  cmd_switch_on && !ctrl[`DSS_CW_ENABLE_OP];
      shutting_down <= next_state == DSS_OP_ENABLED && cmd_shutdown;
      fast_stopping <= next_state == DSS_QUICK_STOP; // [R13]
      jogging <= next_state == DSS_OP_ENABLED &&
                 ctrl[`DSS_CW_ENABLE_OP] && ctrl[`DSS_CW_JOG]; // [R18]
      reverse <= next_state == DSS_OP_ENABLED &&
                 ctrl[`DSS_CW_ENABLE_OP] && ctrl[`DSS_CW_REVERSE];
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge clock) begin
    if (sys_rst || !reg_read) begin
      reg_rdata <= 16'h0000;
    end else begin
      case (reg_addr)
        ADDR_W'(`DSS_ADDR_CTRL): reg_rdata <= ctrl;
        ADDR_W'(`DSS_ADDR_STATUS): reg_rdata <= status_word;
        ADDR_W'(`DSS_ADDR_STATE): reg_rdata <= {13'h0000, seq_state};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  default clocking dss_cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_reset_not_ready: assert property ( // [R2]
    $past(sys_rst) |-> seq_state == `DSS_CODE_NOT_READY)
    else $error("State not reset to not ready.");
  a_init_leaves: assert property ( // [R3]
    state == DSS_NOT_READY && init_done && !trip_event
    |=> state == DSS_SO_DISABLED)
    else $error("Initialisation done did not reach disabled.");
  a_ready_switch: assert property ( // [R5]
    state == DSS_READY && cmd_switch_on && !trip_event
    |=> state == DSS_SWITCHED_ON)
    else $error("Switch-on command ignored.");
  a_op_dv_direct: assert property ( // [R11]
    state == DSS_OP_ENABLED && cmd_disable_voltage && !trip_event
    |=> state == DSS_SO_DISABLED)
    else $error("Disable voltage did not leave operation directly.");
  a_trip_priority: assert property ( // [R24]
    trip && state != DSS_FAULT_REACT |=> state == DSS_FAULT_REACT
    ##1 seq_state == `DSS_CODE_FAULTED || seq_state ==
    `DSS_CODE_FAULT_REACT)
    else $error("Trip did not enter fault reaction.");
  a_reset_edge_only: assert property ( // [R20]
    state == DSS_FAULTED && $past(ctrl[`DSS_CW_FAULT_RESET]) &&
    $past(state) == DSS_FAULTED && !trip_event |=> state == DSS_FAULTED)
    else $error("Fault reset taken on a level.");
  a_stop_waits: assert property ( // [R7]
    state == DSS_OP_ENABLED && !stop_done && !cmd_shutdown
    && !cmd_quick_stop && !cmd_disable_voltage
    |=> state != DSS_SWITCHED_ON)
    else $error("Stop finished before the stop function.");
  a_qs_exit: assert property ( // [R23]
    state == DSS_QUICK_STOP ##1 state != DSS_QUICK_STOP
    |-> state inside {DSS_SO_DISABLED, DSS_FAULT_REACT})
    else $error("Quick stop left to a wrong state.");
  a_status_bits: assert property ( // [R22]
    ##1 status_word[`DSS_SW_SO_DISABLED] == (state == DSS_SO_DISABLED)
    && status_word[`DSS_SW_SWITCHED_ON] ==
    (state inside {DSS_SWITCHED_ON, DSS_OP_ENABLED}))
    else $error("Status bits disagree with state.");

  c_run: cover property (state == DSS_SWITCHED_ON ##1
    state == DSS_OP_ENABLED);
  c_quick_stop: cover property (state == DSS_QUICK_STOP ##1
    state == DSS_SO_DISABLED);
  c_fault_cycle: cover property (state == DSS_FAULTED ##1
    state == DSS_SO_DISABLED);

endmodule : dss_sequencer
`default_nettype wire
